// [design/urx_ep_ctrl.sv]
// Function
// - host: writing one to bit 7 zeroes the receive data toggle.
// - host: STALL received sets bit 6 and the endpoint event bit.
// - host: software sets bit 5 for IN; cleared when packet-ready sets.
// - flush bit discards next packet, resets pointer, clears packet-ready.
// - isochronous: CRC or stuff error sets bit 3 with packet-ready.
// - host bulk: NAKs beyond limit set bit 3 and halt endpoint.
// - host non-iso: three failed attempts set bit 2 and event bit.
// - bit 1 reads one whenever the receive FIFO is full.
// - received data packet sets bit 0 and the endpoint event bit.
// - auto-release clears packet-ready after a max-size packet unload.
// - device: transmitted STALL sets bit 6 until software clears.
// - device: bit 5 held makes endpoint answer STALL, not isochronous.
// - device: bit 3 read-only, zero outside isochronous mode.
// - device iso: dropped OUT packet sets bit 2; zero in bulk.
// - device: writing one to bit 7 zeroes the receive toggle.
// - low control byte resets to zero in both views.
// - high byte toggle bit reports the current receive toggle.
// - max payload for auto-release is bits 10:0 of max-packet.
//
// The APB register port is this design's own decision.
module urx_ep_ctrl #(
  parameter int MAXP_W = 11
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pkt_received,
  input wire logic pkt_bad_crc,
  input wire logic stall_received,
  input wire logic stall_sent,
  input wire logic nak_received,
  input wire logic attempt_no_data,
  input wire logic out_dropped,
  input wire logic fifo_full,
  input wire logic toggle_flip,
  input wire logic pkt_unloaded,
  input wire logic [MAXP_W-1:0] unload_bytes,
  output logic toggle_clear_strobe,
  output logic flush_strobe,
  output logic toggle_state,
  output logic in_request,
  output logic send_stall,
  output logic endpoint_event_bit,
  output logic ep_halt
);
  urx_reg_if bus ();

  urx_apb_slave urx_apb_slave_inst (
    .clock(clock),
    .srst(srst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .bus(bus)
  );

  localparam int NAK_LIMIT_W_L = urx_pkg::NAK_LIMIT_W;
  logic rx_packet_ready;
  logic stalled;
  logic req_or_stall;
  logic crc_error_flag;
  logic nak_timeout_flag;
  logic err_or_over;
  logic auto_release;
  logic iso;
  logic host_mode;
  logic [NAK_LIMIT_W_L-1:0] nak_limit;
  logic [MAXP_W-1:0] payload_limit;
  logic [NAK_LIMIT_W_L-1:0] nak_cnt;
  logic [1:0] retry_cnt;
  logic flush_q;
  logic clr_q;
  logic event_q;

  logic next_rx_packet_ready;
  logic next_stalled;
  logic next_req_or_stall;
  logic next_crc_error_flag;
  logic next_nak_timeout_flag;
  logic next_err_or_over;
  logic next_auto_release;
  logic next_iso;
  logic next_host_mode;
  logic [NAK_LIMIT_W_L-1:0] next_nak_limit;
  logic [MAXP_W-1:0] next_payload_limit;
  logic [NAK_LIMIT_W_L-1:0] next_nak_cnt;
  logic [1:0] next_retry_cnt;
  logic next_toggle_state;
  logic next_flush_q;
  logic next_clr_q;
  logic next_event_q;

  logic wr_low;
  logic wr_high;
  logic wr_maxp;
  logic wr_cfg;
  logic [7:0] low_view;
  logic [7:0] high_view;
  logic bulk_host;
  logic retry_hit;
  logic nak_hit;
  logic auto_hit;

  // register write selects
  assign wr_low = bus.wr_en && bus.idx == urx_pkg::IDX_CTRL_LOW;
  assign wr_high = bus.wr_en && bus.idx == urx_pkg::IDX_CTRL_HIGH;
  assign wr_maxp = bus.wr_en && bus.idx == urx_pkg::IDX_MAX_PACKET;
  assign wr_cfg = bus.wr_en && bus.idx == urx_pkg::IDX_CONFIG;
  assign bulk_host = host_mode && !iso;

  // event qualifiers
  assign retry_hit = bulk_host && attempt_no_data &&
                     retry_cnt == urx_pkg::RETRY_LIMIT - 2'h1;
  assign nak_hit = bulk_host && nak_received && !nak_timeout_flag &&
                   nak_limit != '0 && nak_cnt == nak_limit;
  assign auto_hit = auto_release && pkt_unloaded &&
                    unload_bytes == payload_limit;

  // low byte as seen by software in the current mode
  always_comb begin
    low_view = 8'h00;
    low_view[urx_pkg::BIT_STALLED] = stalled;
    low_view[urx_pkg::BIT_REQ_OR_STALL] = req_or_stall;
    low_view[urx_pkg::BIT_FULL] = fifo_full;
    low_view[urx_pkg::BIT_RX_READY] = rx_packet_ready;
    if (host_mode) begin
      low_view[urx_pkg::BIT_DATA_ERR] = iso ? crc_error_flag :
                                        nak_timeout_flag;
      low_view[urx_pkg::BIT_ERR_OR_OVER] = err_or_over & ~iso;
    end else begin
      low_view[urx_pkg::BIT_DATA_ERR] = crc_error_flag & iso;
      low_view[urx_pkg::BIT_ERR_OR_OVER] = err_or_over & iso;
    end
  end

  // high byte: only the fields this block owns
  always_comb begin
    high_view = 8'h00;
    high_view[urx_pkg::BIT_AUTO_RELEASE] = auto_release;
    high_view[urx_pkg::BIT_ISO] = iso;
    high_view[urx_pkg::BIT_TOGGLE_STATE] = toggle_state;
  end

  // read mux and address decode
  always_comb begin
    bus.rdata = 32'h0000_0000;
    bus.hit = 1'b1;
    case (bus.idx)
      urx_pkg::IDX_CTRL_LOW: bus.rdata[7:0] = low_view;
      urx_pkg::IDX_CTRL_HIGH: bus.rdata[7:0] = high_view;
      urx_pkg::IDX_MAX_PACKET: bus.rdata[MAXP_W-1:0] = payload_limit;
      urx_pkg::IDX_CONFIG: begin
        bus.rdata[urx_pkg::BIT_HOST_MODE] = host_mode;
        bus.rdata[urx_pkg::NAK_LIMIT_LSB +: NAK_LIMIT_W_L] = nak_limit;
      end
      default: bus.hit = 1'b0;
    endcase
  end

  // status and command next values; hardware sets are applied last
  always_comb begin
    next_rx_packet_ready = rx_packet_ready;
    next_stalled = stalled;
    next_req_or_stall = req_or_stall;
    next_crc_error_flag = crc_error_flag;
    next_nak_timeout_flag = nak_timeout_flag;
    next_err_or_over = err_or_over;
    next_nak_cnt = nak_cnt;
    next_retry_cnt = retry_cnt;
    next_toggle_state = toggle_state;
    next_flush_q = 1'b0;
    next_clr_q = 1'b0;
    next_event_q = 1'b0;
    // receive toggle follows accepted packets
    if (toggle_flip) begin
      next_toggle_state = ~toggle_state;
    end
    if (auto_hit) begin
      next_rx_packet_ready = 1'b0;
    end
    if (wr_low) begin
      // writing one is ignored so a read-modify-write cannot set a flag
      if (!bus.wdata[urx_pkg::BIT_RX_READY]) begin
        next_rx_packet_ready = 1'b0;
      end
      if (!bus.wdata[urx_pkg::BIT_STALLED]) begin
        next_stalled = 1'b0;
      end
      if (!bus.wdata[urx_pkg::BIT_ERR_OR_OVER]) begin
        next_err_or_over = 1'b0;
      end
      if (host_mode && !iso && !bus.wdata[urx_pkg::BIT_DATA_ERR]) begin
        next_nak_timeout_flag = 1'b0;
        next_nak_cnt = '0;
      end
      next_req_or_stall = bus.wdata[urx_pkg::BIT_REQ_OR_STALL];
      if (bus.wdata[urx_pkg::BIT_FLUSH]) begin
        next_flush_q = 1'b1;
        next_rx_packet_ready = 1'b0;
      end
      if (bus.wdata[urx_pkg::BIT_TOGGLE_CLEAR]) begin
        next_clr_q = 1'b1;
        next_toggle_state = 1'b0;
      end
    end
    // retry counting in host bulk or interrupt mode
    if (bulk_host && attempt_no_data) begin
      next_retry_cnt = retry_hit ? 2'h0 : retry_cnt + 2'h1;
    end
    if (retry_hit) begin
      next_err_or_over = 1'b1;
      next_event_q = 1'b1;
    end
    // nak persistence; a zero limit disables the timeout
    if (bulk_host && nak_received && !nak_timeout_flag && !nak_hit) begin
      next_nak_cnt = nak_cnt + 1'b1;
    end
    if (nak_hit) begin
      next_nak_timeout_flag = 1'b1;
    end
    if (!host_mode && iso && out_dropped) begin
      next_err_or_over = 1'b1;
    end
    if (host_mode ? stall_received : stall_sent) begin
      next_stalled = 1'b1;
      next_event_q = next_event_q | host_mode;
    end
    if (pkt_received) begin
      next_rx_packet_ready = 1'b1;
      next_event_q = 1'b1;
      next_retry_cnt = 2'h0;
      next_nak_cnt = '0;
      if (host_mode) begin
        next_req_or_stall = 1'b0;
      end
    end
    // crc flag lives only as long as packet-ready
    if (pkt_received) begin
      next_crc_error_flag = iso & pkt_bad_crc;
    end else if (!next_rx_packet_ready) begin
      next_crc_error_flag = 1'b0;
    end
  end

  // configuration next values
  always_comb begin
    next_auto_release = auto_release;
    next_iso = iso;
    next_host_mode = host_mode;
    next_nak_limit = nak_limit;
    next_payload_limit = payload_limit;
    if (wr_high) begin
      next_auto_release = bus.wdata[urx_pkg::BIT_AUTO_RELEASE];
      next_iso = bus.wdata[urx_pkg::BIT_ISO];
    end
    if (wr_maxp) begin
      next_payload_limit = bus.wdata[MAXP_W-1:0];
    end
    if (wr_cfg) begin
      next_host_mode = bus.wdata[urx_pkg::BIT_HOST_MODE];
      next_nak_limit = bus.wdata[urx_pkg::NAK_LIMIT_LSB +: NAK_LIMIT_W_L];
    end
  end

  // all state to zero on reset
  always_ff @(posedge clock) begin
    if (srst) begin
      rx_packet_ready <= urx_pkg::CTRL_LOW_RESET[0];
      stalled <= 1'b0;
      req_or_stall <= 1'b0;
      crc_error_flag <= 1'b0;
      nak_timeout_flag <= 1'b0;
      err_or_over <= 1'b0;
      auto_release <= 1'b0;
      iso <= 1'b0;
      host_mode <= 1'b0;
      nak_limit <= urx_pkg::NAK_LIMIT_RESET;
      payload_limit <= urx_pkg::MAX_PACKET_RESET;
      nak_cnt <= '0;
      retry_cnt <= 2'h0;
      toggle_state <= 1'b0;
      flush_q <= 1'b0;
      clr_q <= 1'b0;
      event_q <= 1'b0;
    end else begin
      rx_packet_ready <= next_rx_packet_ready;
      stalled <= next_stalled;
      req_or_stall <= next_req_or_stall;
      crc_error_flag <= next_crc_error_flag;
      nak_timeout_flag <= next_nak_timeout_flag;
      err_or_over <= next_err_or_over;
      auto_release <= next_auto_release;
      iso <= next_iso;
      host_mode <= next_host_mode;
      nak_limit <= next_nak_limit;
      payload_limit <= next_payload_limit;
      nak_cnt <= next_nak_cnt;
      retry_cnt <= next_retry_cnt;
      toggle_state <= next_toggle_state;
      flush_q <= next_flush_q;
      clr_q <= next_clr_q;
      event_q <= next_event_q;
    end
  end

  // outputs toward the packet engine
  assign flush_strobe = flush_q;
  assign toggle_clear_strobe = clr_q;
  assign endpoint_event_bit = event_q;
  assign in_request = host_mode & req_or_stall;
  assign send_stall = ~host_mode & ~iso & req_or_stall;
  assign ep_halt = bulk_host & nak_timeout_flag;

  property p_toggle_clear;
    @(posedge clock) disable iff (srst)
    wr_low && bus.wdata[urx_pkg::BIT_TOGGLE_CLEAR]
      |=> !toggle_state && toggle_clear_strobe;
  endproperty
  a_toggle_clear: assert property (p_toggle_clear)
    else $error("toggle clear did not zero the toggle");

  property p_stall_seen;
    @(posedge clock) disable iff (srst)
    host_mode && stall_received |=> stalled && endpoint_event_bit;
  endproperty
  a_stall_seen: assert property (p_stall_seen)
    else $error("stall received not flagged");

  property p_inreq_drop;
    @(posedge clock) disable iff (srst)
    host_mode && pkt_received |=> rx_packet_ready && !in_request;
  endproperty
  a_inreq_drop: assert property (p_inreq_drop)
    else $error("in request not dropped on packet ready");

  property p_flush;
    @(posedge clock) disable iff (srst)
    wr_low && bus.wdata[urx_pkg::BIT_FLUSH] && !pkt_received
      |=> flush_strobe && !rx_packet_ready ##1 !flush_strobe;
  endproperty
  a_flush: assert property (p_flush)
    else $error("flush did not pulse or clear packet ready");

  property p_crc_follows;
    @(posedge clock) disable iff (srst)
    crc_error_flag |-> rx_packet_ready && iso;
  endproperty
  a_crc_follows: assert property (p_crc_follows)
    else $error("crc flag without packet ready");

  property p_nak_halt;
    @(posedge clock) disable iff (srst)
    nak_hit |=> ep_halt && low_view[urx_pkg::BIT_DATA_ERR];
  endproperty
  a_nak_halt: assert property (p_nak_halt)
    else $error("nak timeout did not halt");

  property p_retry;
    @(posedge clock) disable iff (srst)
    bulk_host && attempt_no_data && retry_cnt == 2'h2
      |=> low_view[urx_pkg::BIT_ERR_OR_OVER] && endpoint_event_bit;
  endproperty
  a_retry: assert property (p_retry)
    else $error("third failed attempt not flagged");

  property p_full;
    @(posedge clock) disable iff (srst)
    bus.idx == urx_pkg::IDX_CTRL_LOW
      |-> bus.rdata[urx_pkg::BIT_FULL] == fifo_full;
  endproperty
  a_full: assert property (p_full)
    else $error("full bit differs from fifo state");

  property p_ready;
    @(posedge clock) disable iff (srst)
    pkt_received |=> rx_packet_ready && endpoint_event_bit;
  endproperty
  a_ready: assert property (p_ready)
    else $error("packet ready or event missing");

  property p_auto;
    @(posedge clock) disable iff (srst)
    auto_hit && !pkt_received |=> !rx_packet_ready;
  endproperty
  a_auto: assert property (p_auto)
    else $error("auto release failed");

  property p_stall_out;
    @(posedge clock) disable iff (srst)
    send_stall |-> !iso && !host_mode && low_view[urx_pkg::BIT_REQ_OR_STALL];
  endproperty
  a_stall_out: assert property (p_stall_out)
    else $error("stall driven in wrong mode");

  property p_bulk_zero;
    @(posedge clock) disable iff (srst)
    !host_mode && !iso |-> low_view[3:2] == 2'h0;
  endproperty
  a_bulk_zero: assert property (p_bulk_zero)
    else $error("device bulk error bits not zero");

  property p_set_wins;
    @(posedge clock) disable iff (srst)
    wr_low && !bus.wdata[urx_pkg::BIT_STALLED] && !host_mode && stall_sent
      |=> stalled;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clear beat a hardware set");
endmodule

// [include/urx_pkg.sv]
package urx_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_MAX_PACKET = 10'h114;
  localparam logic [9:0] IDX_CTRL_LOW = 10'h116;
  localparam logic [9:0] IDX_CTRL_HIGH = 10'h117;
  localparam logic [9:0] IDX_CONFIG = 10'h118;
  // low control byte fields
  localparam int BIT_TOGGLE_CLEAR = 7;
  localparam int BIT_STALLED = 6;
  localparam int BIT_REQ_OR_STALL = 5;
  localparam int BIT_FLUSH = 4;
  localparam int BIT_DATA_ERR = 3;
  localparam int BIT_ERR_OR_OVER = 2;
  localparam int BIT_FULL = 1;
  localparam int BIT_RX_READY = 0;
  // high control byte fields
  localparam int BIT_AUTO_RELEASE = 7;
  localparam int BIT_ISO = 6;
  localparam int BIT_TOGGLE_STATE = 1;
  // configuration register fields
  localparam int BIT_HOST_MODE = 0;
  localparam int NAK_LIMIT_LSB = 8;
  localparam int NAK_LIMIT_W = 8;
  // reset values
  localparam logic [7:0] CTRL_LOW_RESET = 8'h00;
  localparam logic [10:0] MAX_PACKET_RESET = 11'h000;
  localparam logic [7:0] NAK_LIMIT_RESET = 8'h00;
  // receive attempts without data before the error flag
  localparam logic [1:0] RETRY_LIMIT = 2'h3;
endpackage

// [include/urx_reg_if.sv]
interface urx_reg_if;
  logic wr_en;
  logic [9:0] idx;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic hit;
  modport slave (
    output wr_en,
    output idx,
    output wdata,
    input rdata,
    input hit
  );
  modport regs (
    input wr_en,
    input idx,
    input wdata,
    output rdata,
    output hit
  );
endinterface

// [design/urx_apb_slave.sv]
module urx_apb_slave (
  input wire logic clock,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  urx_reg_if.slave bus
);
  logic ready_q;
  logic [31:0] rdata_q;
  logic err_q;
  logic next_ready_q;
  logic [31:0] next_rdata_q;
  logic next_err_q;

  // word index straight from the address; low two bits ignored
  assign bus.idx = paddr[11:2];
  assign bus.wdata = pwdata;
  // write lands only at the completing access edge
  assign bus.wr_en = psel & penable & pwrite & ready_q & bus.hit;
  assign pready = ready_q;
  assign prdata = rdata_q;
  assign pslverr = err_q;

  // capture answer in setup so read data comes from flops
  always_comb begin
    next_ready_q = ready_q;
    next_rdata_q = rdata_q;
    next_err_q = err_q;
    if (psel && !penable) begin
      next_ready_q = 1'b1;
      next_rdata_q = pwrite ? 32'h0000_0000 : bus.rdata;
      next_err_q = ~bus.hit;
    end else if (psel && penable && ready_q) begin
      next_ready_q = 1'b0;
      next_err_q = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ready_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else begin
      ready_q <= next_ready_q;
      rdata_q <= next_rdata_q;
      err_q <= next_err_q;
    end
  end
endmodule

// [tb/urx_link_model.sv]
module urx_link_model (
  input wire logic clock,
  input wire logic in_request,
  input wire logic send_stall,
  output logic pkt_received,
  output logic pkt_bad_crc,
  output logic stall_received,
  output logic stall_sent,
  output logic nak_received,
  output logic attempt_no_data,
  output logic out_dropped,
  output logic fifo_full,
  output logic toggle_flip
);
  timeunit 1ns;
  timeprecision 100ps;
  int reply_wait = 1;
  logic [6:0] fire = 7'h00;
  assign {toggle_flip, out_dropped, nak_received, stall_sent} = fire[6:3];
  assign {attempt_no_data, stall_received, pkt_received} = fire[2:0];
  initial begin
    pkt_bad_crc = 1'b0;
    fifo_full = 1'b0;
  end
  // one-cycle link event; the qualifier flips once the pulse is gone
  task automatic ev(input int k, input logic crc);
    @(posedge clock);
    fire <= 7'h01 << k;
    pkt_bad_crc <= crc;
    @(posedge clock);
    fire <= 7'h00;
    pkt_bad_crc <= ~crc;
  endtask
  task automatic set_full(input logic v);
    @(posedge clock);
    fifo_full <= v;
  endtask
  // far side answers an IN token with data, after a settable wait
  initial begin
    forever begin
      @(posedge clock);
      if (in_request === 1'b1) begin
        repeat (reply_wait) @(posedge clock);
        ev(0, 1'b0);
      end else if (send_stall === 1'b1) begin
        ev(3, 1'b0);
      end
    end
  end
endmodule

// [tb/test_usb_rx_endpoint_ctrl_status.sv]
module test_usb_rx_endpoint_ctrl_status;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, pkt_unloaded = 1'b0;
  logic [10:0] unload_bytes = 11'h000;
  logic pkt_received, pkt_bad_crc, stall_received, stall_sent, nak_received;
  logic attempt_no_data, out_dropped, fifo_full, toggle_flip;
  logic toggle_clear_strobe, flush_strobe, toggle_state, in_request;
  logic send_stall, endpoint_event_bit, ep_halt;
  int error_cnt = 0, checks = 0, ev_cnt = 0, fl_cnt = 0, tc_cnt = 0, e0;
  localparam logic [11:0] A_MAXP = 12'h450, A_LOW = 12'h458;
  localparam logic [11:0] A_HIGH = 12'h45c, A_CFG = 12'h460;

  always #4 clock = ~clock;

  urx_ep_ctrl urx_ep_ctrl_inst (.clock(clock), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pkt_received(pkt_received), .pkt_bad_crc(pkt_bad_crc),
    .stall_received(stall_received), .stall_sent(stall_sent),
    .nak_received(nak_received), .attempt_no_data(attempt_no_data),
    .out_dropped(out_dropped), .fifo_full(fifo_full),
    .toggle_flip(toggle_flip), .pkt_unloaded(pkt_unloaded),
    .unload_bytes(unload_bytes), .toggle_clear_strobe(toggle_clear_strobe),
    .flush_strobe(flush_strobe), .toggle_state(toggle_state),
    .in_request(in_request), .send_stall(send_stall),
    .endpoint_event_bit(endpoint_event_bit), .ep_halt(ep_halt));

  urx_link_model urx_link_model_inst (.clock(clock), .in_request(in_request),
    .send_stall(send_stall), .pkt_received(pkt_received),
    .pkt_bad_crc(pkt_bad_crc), .stall_received(stall_received),
    .stall_sent(stall_sent), .nak_received(nak_received),
    .attempt_no_data(attempt_no_data), .out_dropped(out_dropped),
    .fifo_full(fifo_full), .toggle_flip(toggle_flip));

  // pulses are counted so scenarios can judge them after the fact
  always @(posedge clock) begin
    if (endpoint_event_bit === 1'b1) ev_cnt++;
    if (flush_strobe === 1'b1) fl_cnt++;
    if (toggle_clear_strobe === 1'b1) tc_cnt++;
  end

  task automatic complete_run();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // apb cycle; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t no pready", $time);
      complete_run();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
    chk({31'h0, e}, 32'h0);
  endtask
  task automatic ev(input int k, input logic crc);
    urx_link_model_inst.ev(k, crc);
  endtask
  task automatic unload(input logic [10:0] n);
    @(posedge clock);
    pkt_unloaded <= 1'b1;
    unload_bytes <= n;
    @(posedge clock);
    pkt_unloaded <= 1'b0;
  endtask

  task automatic t_reset();
    logic [31:0] q;
    logic e;
    rd(A_MAXP, 32'h0);
    rd(A_LOW, 32'h0);
    rd(A_HIGH, 32'h0);
    rd(A_CFG, 32'h0);
    apb(1'b0, 12'h464, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
  endtask
  // host IN request answered slowly, then flushed
  task automatic t_host_rx();
    int n;
    urx_link_model_inst.reply_wait = 6;
    wr(A_CFG, 32'h1);
    e0 = ev_cnt;
    wr(A_LOW, 32'h20);
    for (n = 0; n < 40 && ev_cnt == e0; n++) @(posedge clock);
    chk(ev_cnt - e0, 1);
    chk({31'h0, in_request}, 32'h0);
    rd(A_LOW, 32'h01);
    e0 = fl_cnt;
    wr(A_LOW, 32'h10);
    rd(A_LOW, 32'h0);
    chk(fl_cnt - e0, 1);
  endtask
  task automatic t_host_err();
    e0 = ev_cnt;
    ev(2, 1'b0);
    ev(2, 1'b0);
    rd(A_LOW, 32'h0);
    ev(2, 1'b0);
    rd(A_LOW, 32'h04);
    chk(ev_cnt - e0, 1);
    wr(A_LOW, 32'h0);
    ev(1, 1'b0);
    rd(A_LOW, 32'h40);
    chk(ev_cnt - e0, 2);
    wr(A_LOW, 32'h0);
    wr(A_CFG, 32'h201);
    ev(4, 1'b0);
    ev(4, 1'b0);
    rd(A_LOW, 32'h0);
    ev(4, 1'b0);
    rd(A_LOW, 32'h08);
    chk({31'h0, ep_halt}, 32'h1);
    wr(A_LOW, 32'h0);
    @(posedge clock);
    chk({31'h0, ep_halt}, 32'h0);
  endtask
  task automatic t_host_iso();
    wr(A_HIGH, 32'h40);
    ev(0, 1'b1);
    rd(A_LOW, 32'h09);
    repeat (3) ev(2, 1'b0);
    rd(A_LOW, 32'h09);
    wr(A_LOW, 32'h0);
    rd(A_LOW, 32'h0);
  endtask
  task automatic t_auto();
    wr(A_HIGH, 32'h80);
    wr(A_MAXP, 32'hffff_f840);
    rd(A_MAXP, 32'h040);
    ev(0, 1'b0);
    unload(11'h03f);
    rd(A_LOW, 32'h01);
    unload(11'h040);
    rd(A_LOW, 32'h0);
    ev(6, 1'b0);
    rd(A_HIGH, 32'h82);
    chk({31'h0, toggle_state}, 32'h1);
    e0 = tc_cnt;
    wr(A_LOW, 32'h80);
    rd(A_HIGH, 32'h80);
    chk(tc_cnt - e0, 1);
  endtask
  task automatic t_device();
    wr(A_CFG, 32'h0);
    wr(A_HIGH, 32'h0);
    e0 = ev_cnt;
    wr(A_LOW, 32'h20);
    @(posedge clock);
    chk({31'h0, send_stall}, 32'h1);
    repeat (10) @(posedge clock);
    rd(A_LOW, 32'h60);
    chk(ev_cnt - e0, 0);
    wr(A_LOW, 32'h0);
    repeat (4) @(posedge clock);
    wr(A_LOW, 32'h0);
    rd(A_LOW, 32'h0);
    wr(A_HIGH, 32'h40);
    wr(A_LOW, 32'h20);
    @(posedge clock);
    chk({31'h0, send_stall}, 32'h0);
    wr(A_LOW, 32'h0);
    ev(5, 1'b0);
    rd(A_LOW, 32'h04);
    wr(A_LOW, 32'h0);
    wr(A_HIGH, 32'h0);
    ev(5, 1'b0);
    ev(0, 1'b1);
    rd(A_LOW, 32'h01);
    wr(A_LOW, 32'h0);
    urx_link_model_inst.set_full(1'b1);
    rd(A_LOW, 32'h02);
    urx_link_model_inst.set_full(1'b0);
    rd(A_LOW, 32'h0);
    ev(6, 1'b0);
    rd(A_HIGH, 32'h02);
    wr(A_LOW, 32'h80);
    rd(A_HIGH, 32'h0);
  endtask

  initial begin
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    t_reset();
    t_host_rx();
    t_host_err();
    t_host_iso();
    t_auto();
    t_device();
    complete_run();
  end
endmodule
